// *** rtl/tcs_core.sv ***
// Function
// R1: generator enable bit 2 makes the generator drive timing outputs.
// R2: software programs generator settings before raising the generator enable.
// R3: with generator and master enable both low, generated outputs stay low.
// R4: internal generator enable is generator enable OR master enable.
// R5: internal detector enable is detector enable OR master enable.
// R6: master enable bit 0 turns on generator and detector regardless.
// R7: to run one side only, software keeps master low, sets bit 2 or bit 3.
// R8: double-buffered settings load at next frame start while commit bit set.
// R9: event bits 31:16 set when frame syncs 0 to 15 go active.
// R10: event bit 13 set on first cycle generated active video asserts.
// R11: event bit 12 set on first cycle generated vertical blank asserts.
// R12: after lock, event bit 11 set when input active video asserts.
// R13: after lock, event bit 10 set when input vertical blank asserts.
// R14: event bit 9 set when any detection-enabled signal loses lock.
// R15: event bit 8 set when all detection-enabled signals have locked.
// R16: lock typically takes three to five frames; no guaranteed bound.
// R17: writing one clears a set event bit; zeros change nothing.
// R18: lock-detail bits 21 and 20 high while chroma and video timing stable.
// R19: lock-detail bits 19..16 high while hsync, vsync, hblank, vblank stable.
// R20: detector disabled stops detection and drives all lock bits low.
// R21: writing one clears a set lock-detail bit.
// R22: interrupt-mask register lets each event bit raise the interrupt.
// R23: interrupt output high while any event bit and its mask bit set.
`timescale 1ns/100ps
`default_nettype none
module tcs_core
(
   // clock and reset
   input  wire logic                           clock,
   input  wire logic                           resetn,
   // register port
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   input  wire logic [7:0]                     reg_addr,
   input  wire logic [31:0]                    reg_wdata,
   output var  logic [31:0]                    reg_rd_data,
   output var  logic                           reg_rd_valid,
   // generator side
   input  wire logic                           frame_start,
   input  wire logic                           gen_pic_raw,
   input  wire logic                           gen_vgap_raw,
   input  wire logic [tcs_pkg::NUM_FSYNC-1:0]  gen_fsync_raw,
   input  wire logic [tcs_pkg::SET_W-1:0]      shadow_settings,
   output var  logic                           gen_on,
   output var  logic [tcs_pkg::SET_W-1:0]      active_settings,
   output var  logic                           out_picture_start_flag,
   output var  logic                           out_vertical_gap_flag,
   output var  logic [tcs_pkg::NUM_FSYNC-1:0]  fsync_out,
   // detector side
   input  wire logic                           in_picture_start_flag,
   input  wire logic                           in_vertical_gap_flag,
   input  wire logic [tcs_pkg::NUM_SIG-1:0]    sig_detect_sel,
   input  wire logic [tcs_pkg::NUM_SIG-1:0]    sig_stable,
   output var  logic                           det_on,
   output var  logic                           detector_locked,
   // interrupt
   output var  logic                           irq
);

   typedef struct packed
   {
      logic [tcs_pkg::CTRL_W-1:0]    ctrl;
      logic [31:0]                   evt;
      logic [tcs_pkg::NUM_SIG-1:0]   detail;
      logic [31:0]                   irq_mask;
      logic [31:0]                   rdata;
      logic                          rvalid;
      logic [tcs_pkg::SET_W-1:0]     active;
      logic                          out_pic;
      logic                          out_vgap;
      logic [tcs_pkg::NUM_FSYNC-1:0] fsync;
      logic                          in_pic;
      logic                          in_vgap;
      logic                          irq;
   } tcs_core_s;

   tcs_core_s st;
   tcs_core_s next_st;

   tcs_lock_if lk ();

   logic                          gen_en;
   logic                          det_en;
   logic                          wr_ctrl;
   logic                          wr_evt;
   logic                          wr_lock;
   logic                          wr_mask;
   logic [31:0]                   evt_set;
   logic [31:0]                   evt_clr;
   logic [31:0]                   detail_word;
   logic [tcs_pkg::NUM_SIG-1:0]   detail_clr;
   logic [tcs_pkg::NUM_FSYNC-1:0] fsync_rise;

   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] off);
      hit = (addr == off);
   endfunction

   // one decode per register, shared by all update terms
   assign wr_ctrl = reg_wr & hit(reg_addr, tcs_pkg::OFF_CTRL);
   assign wr_evt  = reg_wr & hit(reg_addr, tcs_pkg::OFF_EVT);
   assign wr_lock = reg_wr & hit(reg_addr, tcs_pkg::OFF_LOCK);
   assign wr_mask = reg_wr & hit(reg_addr, tcs_pkg::OFF_MASK);

   // internal enables
   assign gen_en = st.ctrl[tcs_pkg::CTRL_GEN]
                 | st.ctrl[tcs_pkg::CTRL_MASTER];              // [R4] [R6]
   assign det_en = st.ctrl[tcs_pkg::CTRL_DET]
                 | st.ctrl[tcs_pkg::CTRL_MASTER];              // [R5] [R6]

   assign lk.det_en = det_en;
   assign lk.sel = sig_detect_sel;
   assign lk.stable = sig_stable;

   tcs_lock_mon u_lock_mon
   (
      .clock  (clock),
      .resetn (resetn),
      .lk     (lk.mon)
   );

   // one edge detector per frame sync, gated like the output it feeds
   for (genvar i = 0; i < tcs_pkg::NUM_FSYNC; i++)
   begin : g_fsync_rise
      assign fsync_rise[i] = gen_fsync_raw[i] & gen_en & ~st.fsync[i]; // [R9]
   end

   always_comb
   begin
      next_st = st;
      evt_set = 32'h0000_0000;
      evt_clr = 32'h0000_0000;
      detail_clr = 6'h00;
      detail_word = 32'h0000_0000;
      detail_word[tcs_pkg::LOCK_LO +: tcs_pkg::NUM_SIG] = st.detail;

      // control register write
      if (wr_ctrl)
      begin
         next_st.ctrl = reg_wdata[tcs_pkg::CTRL_W-1:0];
      end
      if (wr_mask)
      begin
         next_st.irq_mask = reg_wdata & tcs_pkg::EVT_IMPL;             // [R22]
      end
      if (wr_evt)
      begin
         evt_clr = reg_wdata;                                          // [R17]
      end
      if (wr_lock)
      begin
         detail_clr = reg_wdata[tcs_pkg::LOCK_LO +: tcs_pkg::NUM_SIG]; // [R21]
      end

      // settings swap only on a frame boundary so a frame never mixes
      if (frame_start && st.ctrl[tcs_pkg::CTRL_COMMIT])
      begin
         next_st.active = shadow_settings;                             // [R8]
      end

      // generated outputs held low while generation is off
      next_st.out_pic = gen_pic_raw & gen_en;                     // [R1] [R3]
      next_st.out_vgap = gen_vgap_raw & gen_en;                   // [R1] [R3]
      next_st.fsync = gen_fsync_raw & {tcs_pkg::NUM_FSYNC{gen_en}};    // [R3]

      // flags rise with the first asserted cycle of each output
      evt_set[tcs_pkg::EVT_FSYNC_LO +: tcs_pkg::NUM_FSYNC] =
         fsync_rise;                                                   // [R9]
      evt_set[tcs_pkg::EVT_OUT_PIC] =
         next_st.out_pic & ~st.out_pic;                                // [R10]
      evt_set[tcs_pkg::EVT_OUT_VGAP] =
         next_st.out_vgap & ~st.out_vgap;                              // [R11]

      // detector edges count only once locked
      next_st.in_pic = in_picture_start_flag;
      next_st.in_vgap = in_vertical_gap_flag;
      evt_set[tcs_pkg::EVT_IN_PIC] = lk.locked
         & in_picture_start_flag & ~st.in_pic;                         // [R12]
      evt_set[tcs_pkg::EVT_IN_VGAP] = lk.locked
         & in_vertical_gap_flag & ~st.in_vgap;                         // [R13]
      // lock time depends on the source; no timeout is imposed
      evt_set[tcs_pkg::EVT_LOCK] = lk.lock_evt;                 // [R15] [R16]
      evt_set[tcs_pkg::EVT_LOSS] = lk.loss_evt;                        // [R14]

      // set wins over a clear in the same cycle
      next_st.evt = ((st.evt & ~evt_clr) | evt_set)
                  & tcs_pkg::EVT_IMPL;                                 // [R17]

      // stable signals re-set at once, so a clear only sticks on change
      next_st.detail = (st.detail & ~detail_clr)
                     | lk.detail_set;                     // [R18] [R19] [R21]
      if (!det_en)
      begin
         next_st.detail = tcs_pkg::DETAIL_RST;                         // [R20]
      end

      next_st.irq = |(next_st.evt & next_st.irq_mask);          // [R22] [R23]

      // read data, registered one cycle after the strobe
      next_st.rvalid = reg_rd;
      next_st.rdata = 32'h0000_0000;
      if (reg_rd)
      begin
         case (reg_addr)
            tcs_pkg::OFF_CTRL:
            begin
               next_st.rdata[tcs_pkg::CTRL_W-1:0] = st.ctrl;
            end
            tcs_pkg::OFF_EVT:
            begin
               next_st.rdata = st.evt;
            end
            tcs_pkg::OFF_LOCK:
            begin
               next_st.rdata = detail_word;
            end
            tcs_pkg::OFF_MASK:
            begin
               next_st.rdata = st.irq_mask;
            end
            default:
            begin
               next_st.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         st <= '0;
         st.ctrl <= tcs_pkg::CTRL_RST;
         st.evt <= tcs_pkg::EVT_RST;
         st.irq_mask <= tcs_pkg::MASK_RST;
         st.active <= tcs_pkg::SET_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign reg_rd_data = st.rdata;
   assign reg_rd_valid = st.rvalid;
   assign gen_on = gen_en;
   assign det_on = det_en;
   assign active_settings = st.active;
   assign out_picture_start_flag = st.out_pic;
   assign out_vertical_gap_flag = st.out_vgap;
   assign fsync_out = st.fsync;
   assign detector_locked = lk.locked;
   assign irq = st.irq;

endmodule
`default_nettype wire

// *** rtl/tcs_pkg.sv ***
`default_nettype none
package tcs_pkg;

   // register offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_EVT  = 8'h04;
   localparam logic [7:0] OFF_LOCK = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0C;

   // core_control field positions
   localparam int unsigned CTRL_MASTER = 0;
   localparam int unsigned CTRL_COMMIT = 1;
   localparam int unsigned CTRL_GEN    = 2;
   localparam int unsigned CTRL_DET    = 3;
   localparam int unsigned CTRL_W      = 4;

   // event_flags field positions
   localparam int unsigned EVT_LOCK     = 8;
   localparam int unsigned EVT_LOSS     = 9;
   localparam int unsigned EVT_IN_VGAP  = 10;
   localparam int unsigned EVT_IN_PIC   = 11;
   localparam int unsigned EVT_OUT_VGAP = 12;
   localparam int unsigned EVT_OUT_PIC  = 13;
   localparam int unsigned EVT_FSYNC_LO = 16;

   // lock_detail field positions, bit 0 of the group is vertical blank
   localparam int unsigned LOCK_LO = 16;
   localparam int unsigned NUM_SIG = 6;

   // widths
   localparam int unsigned NUM_FSYNC = 16;
   localparam int unsigned SET_W     = 32;

   // reset values and implemented-bit masks
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [31:0]       EVT_RST  = 32'h0000_0000;
   localparam logic [31:0]       MASK_RST = 32'h0000_0000;
   localparam logic [31:0]       EVT_IMPL = 32'hFFFF_3F00;
   localparam logic [NUM_SIG-1:0] DETAIL_RST = 6'h00;
   localparam logic [SET_W-1:0]  SET_RST  = 32'h0000_0000;

endpackage
`default_nettype wire

// *** rtl/tcs_lock_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface tcs_lock_if;
   logic                         det_en;
   logic [tcs_pkg::NUM_SIG-1:0]  sel;
   logic [tcs_pkg::NUM_SIG-1:0]  stable;
   logic [tcs_pkg::NUM_SIG-1:0]  detail_set;
   logic                         locked;
   logic                         lock_evt;
   logic                         loss_evt;

   modport mon
   (
      input  det_en,
      input  sel,
      input  stable,
      output detail_set,
      output locked,
      output lock_evt,
      output loss_evt
   );

   modport core
   (
      output det_en,
      output sel,
      output stable,
      input  detail_set,
      input  locked,
      input  lock_evt,
      input  loss_evt
   );
endinterface
`default_nettype wire

// *** rtl/tcs_lock_mon.sv ***
`timescale 1ns/100ps
`default_nettype none
module tcs_lock_mon
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // lock signals
   tcs_lock_if.mon  lk
);

   typedef struct packed
   {
      logic                        locked;
      logic                        lock_evt;
      logic                        loss_evt;
      logic [tcs_pkg::NUM_SIG-1:0] stable;
   } tcs_mon_s;

   tcs_mon_s st;
   tcs_mon_s next_st;
   logic [tcs_pkg::NUM_SIG-1:0] watch;
   logic                        all_ok;

   always_comb
   begin
      next_st = st;
      // disabled signals drop out of both lock and loss terms
      watch = lk.sel & {tcs_pkg::NUM_SIG{lk.det_en}};                // [R20]
      all_ok = (|watch) & (&(lk.stable | ~watch));                     // [R15]
      next_st.locked = all_ok;
      next_st.lock_evt = all_ok & ~st.locked;                          // [R15]
      next_st.loss_evt = |(watch & st.stable & ~lk.stable);            // [R14]
      next_st.stable = lk.stable & watch;
   end

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign lk.locked = st.locked;
   assign lk.lock_evt = st.lock_evt;
   assign lk.loss_evt = st.loss_evt;
   assign lk.detail_set = st.stable;                           // [R18] [R19]

endmodule
`default_nettype wire

// *** tb/tcs_core_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module tcs_core_checker
(
   // clock and reset
   input wire logic                          clock,
   input wire logic                          resetn,
   // register port
   input wire logic                          reg_wr,
   input wire logic [7:0]                    reg_addr,
   input wire logic [31:0]                   reg_wdata,
   // generator and detector
   input wire logic                          gen_on,
   input wire logic                          det_on,
   input wire logic                          gen_pic_raw,
   input wire logic                          out_picture_start_flag,
   input wire logic                          out_vertical_gap_flag,
   input wire logic [tcs_pkg::NUM_FSYNC-1:0] fsync_out,
   input wire logic                          frame_start,
   input wire logic [tcs_pkg::SET_W-1:0]     active_settings,
   input wire logic [tcs_pkg::NUM_SIG-1:0]   sig_detect_sel,
   input wire logic [tcs_pkg::NUM_SIG-1:0]   sig_stable,
   input wire logic                          detector_locked
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   wire logic ctrl_wr = reg_wr && reg_addr == tcs_pkg::OFF_CTRL;
   // lock needs at least one selected signal
   wire logic all_sel = det_on && sig_detect_sel != 6'h00
      && (sig_stable & sig_detect_sel) == sig_detect_sel;

   chk_gen_or_enable :
      assert property (ctrl_wr |=>
         gen_on == ($past(reg_wdata[tcs_pkg::CTRL_GEN])
                  | $past(reg_wdata[tcs_pkg::CTRL_MASTER])))
      else $error("generator enable wrong");
   chk_master_both_on :
      assert property (ctrl_wr && reg_wdata[tcs_pkg::CTRL_MASTER]
         |=> gen_on && det_on)
      else $error("master enable ignored");
   chk_gen_quiet_off :
      assert property (!gen_on |=> !out_picture_start_flag
         && !out_vertical_gap_flag && fsync_out == 16'h0000)
      else $error("generated output while off");
   chk_gen_follows_raw :
      assert property (gen_on |=>
         out_picture_start_flag == $past(gen_pic_raw))
      else $error("generated output wrong");
   chk_settings_hold :
      assert property ($past(resetn) && !$past(frame_start) |->
         $stable(active_settings))
      else $error("settings changed off frame start");
   chk_det_off_unlock :
      assert property (!det_on |=> !detector_locked)
      else $error("lock while detector off");
   chk_unstable_unlock :
      assert property (det_on
         && (sig_stable & sig_detect_sel) != sig_detect_sel
         |=> !detector_locked)
      else $error("lock with unstable signal");
   chk_stable_locks :
      assert property (all_sel[*3] |-> detector_locked)
      else $error("no lock with all stable");
endmodule
bind tcs_core tcs_core_checker chk_u
(
   .clock, .resetn, .reg_wr, .reg_addr, .reg_wdata, .gen_on, .det_on,
   .gen_pic_raw, .out_picture_start_flag, .out_vertical_gap_flag,
   .fsync_out, .frame_start, .active_settings, .sig_detect_sel,
   .sig_stable, .detector_locked
);
`default_nettype wire

// *** tb/tcs_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module tcs_host_model
(
   // clock
   input  wire logic        clock,
   // register port
   output var  logic        reg_wr,
   output var  logic        reg_rd,
   output var  logic [7:0]  reg_addr,
   output var  logic [31:0] reg_wdata,
   input  wire logic [31:0] reg_rd_data,
   input  wire logic        reg_rd_valid
);
   initial
   begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0000_0000;
   end
   // released lines show the inverse so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output bit ok);
      ok = 1'b0;
      d  = 32'hXXXX_XXXX;
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      repeat (3)
      begin
         #1;
         if (!ok && reg_rd_valid === 1'b1)
         begin
            ok = 1'b1;
            d  = reg_rd_data;
         end
         if (!ok)
            @(posedge clock);
      end
   endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clock, resetn, reg_wr, reg_rd, reg_rd_valid, frame_start;
   logic        gen_pic_raw, gen_vgap_raw, gen_on, det_on, irq;
   logic        out_picture_start_flag, out_vertical_gap_flag;
   logic        in_picture_start_flag, in_vertical_gap_flag;
   logic        detector_locked;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rd_data, shadow_settings, active_settings;
   logic [15:0] gen_fsync_raw, fsync_out;
   logic [5:0]  sig_detect_sel, sig_stable;
   int          n_fail, samples_checked;

   tcs_core dut_u
   (
      .clock, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rd_data, .reg_rd_valid, .frame_start, .gen_pic_raw,
      .gen_vgap_raw, .gen_fsync_raw, .shadow_settings, .gen_on,
      .active_settings, .out_picture_start_flag, .out_vertical_gap_flag,
      .fsync_out, .in_picture_start_flag, .in_vertical_gap_flag,
      .sig_detect_sel, .sig_stable, .det_on, .detector_locked, .irq
   );
   tcs_host_model host_u
   (
      .clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rd_data,
      .reg_rd_valid
   );

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic results();
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      bit          ok;
      host_u.rd(a, d, ok);
      if (!ok)
      begin
         n_fail++;
         results();
      end
      else
      begin
         chk($sformatf("reg %h", a), e, d);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic fs();
      @(posedge clock);
      frame_start <= 1'b1;
      @(posedge clock);
      frame_start <= 1'b0;
      cyc(1);
   endtask

   initial
   begin
      n_fail = 0;
      samples_checked = 0;
      resetn = 1'b0;
      {frame_start, gen_pic_raw, gen_vgap_raw} = 3'h0;
      {in_picture_start_flag, in_vertical_gap_flag} = 2'h0;
      gen_fsync_raw = 16'h0000;
      shadow_settings = 32'h0000_0000;
      sig_detect_sel = 6'h00;
      sig_stable = 6'h00;
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      // reset values, last one unmapped
      for (int i = 0; i < 5; i++)
         rdc(8'(4 * i), 32'h0000_0000);
      for (int c = 0; c < 16; c++)
      begin
         host_u.wr(8'h00, 32'(c));
         #1;
         chk("gen_on", 32'(c[2] | c[0]), 32'(gen_on));
         chk("det_on", 32'(c[3] | c[0]), 32'(det_on));
         rdc(8'h00, 32'(c));
      end
      host_u.wr(8'h0C, 32'h0000_2000);
      rdc(8'h0C, 32'h0000_2000);
      host_u.wr(8'h00, 32'h0000_0000);
      @(posedge clock);
      {gen_pic_raw, gen_vgap_raw, gen_fsync_raw} <= {2'h3, 16'hA5A5};
      cyc(3);
      chk("gen pic", 32'h0, 32'(out_picture_start_flag));
      chk("gen vgap", 32'h0, 32'(out_vertical_gap_flag));
      rdc(8'h04, 32'h0000_0000);
      @(posedge clock);
      {gen_pic_raw, gen_vgap_raw, gen_fsync_raw} <= 18'h0;
      shadow_settings <= 32'h1234_5678;
      host_u.wr(8'h00, 32'h0000_0004);
      @(posedge clock);
      {gen_pic_raw, gen_vgap_raw, gen_fsync_raw} <= {2'h3, 16'hA5A5};
      cyc(3);
      chk("gen pic", 32'h1, 32'(out_picture_start_flag));
      chk("gen vgap", 32'h1, 32'(out_vertical_gap_flag));
      chk("fsync", 32'h0000_A5A5, 32'(fsync_out));
      chk("irq", 32'h1, 32'(irq));
      rdc(8'h04, 32'hA5A5_3000);
      @(posedge clock);
      {gen_pic_raw, gen_vgap_raw, gen_fsync_raw} <= 18'h0;
      host_u.wr(8'h04, 32'h0000_2000);
      cyc(1);
      chk("irq", 32'h0, 32'(irq));
      rdc(8'h04, 32'hA5A5_1000);
      host_u.wr(8'h04, 32'h0000_0000);
      rdc(8'h04, 32'hA5A5_1000);
      host_u.wr(8'h04, 32'hFFFF_FFFF);
      rdc(8'h04, 32'h0000_0000);
      fs();
      chk("settings", 32'h0, active_settings);
      host_u.wr(8'h00, 32'h0000_0006);
      fs();
      chk("settings", 32'h1234_5678, active_settings);
      // detector alone; unselected bits 3 and 1 must not matter
      host_u.wr(8'h00, 32'h0000_0008);
      @(posedge clock);
      {sig_detect_sel, sig_stable} <= {6'h35, 6'h3F};
      cyc(4);
      chk("locked", 32'h1, 32'(detector_locked));
      rdc(8'h04, 32'h0000_0100);
      rdc(8'h08, 32'h0035_0000);
      @(posedge clock);
      {in_picture_start_flag, in_vertical_gap_flag} <= 2'h3;
      cyc(2);
      rdc(8'h04, 32'h0000_0D00);
      host_u.wr(8'h04, 32'hFFFF_FFFF);
      @(posedge clock);
      sig_stable <= 6'h37;
      cyc(3);
      rdc(8'h04, 32'h0000_0000);
      @(posedge clock);
      sig_stable <= 6'h36;
      cyc(3);
      chk("locked", 32'h0, 32'(detector_locked));
      rdc(8'h04, 32'h0000_0200);
      host_u.wr(8'h08, 32'h0001_0000);
      rdc(8'h08, 32'h0034_0000);
      host_u.wr(8'h00, 32'h0000_0000);
      cyc(2);
      chk("locked", 32'h0, 32'(detector_locked));
      rdc(8'h08, 32'h0000_0000);
      results();
   end
endmodule
`default_nettype wire
